// ===== core/ttya_ctl.sv
// Test timeout, yellow alarm and assignment clearing control with Avalon-MM registers
//
// Functional notes
// RULE1: With yellow generation enabled, yellow is sent on a network or drop/insert line while it shows sustained signal loss, frame loss or all-ones.
// RULE2: With yellow generation disabled, no yellow is ever sent on any line.
// RULE3: With yellow generation disabled, attached terminal equipment must raise yellow itself for network carrier failures.
// RULE4: With timeout enabled, a user loopback or pattern test ends on its own once the set duration elapses.
// RULE5: Loopbacks requested by the attached terminal equipment are never ended by the timeout.
// RULE6: With timeout disabled, a user test runs until an explicit stop command.
// RULE7: Duration takes whole minutes 1 to 120, resets to 10, and matters only while timeout is enabled.
// RULE8: Remote managers should keep the timeout enabled so an in-band link blocked by a test comes back.
// RULE9: Clear-all empties every timeslot entry of all interfaces including voice and sync data ports.
// RULE10: An interface clear empties only that interface's timeslots.
// RULE11: A slot clear empties only entries owned by the module or sync data ports in that slot.
// RULE12: Every entry hit by a clear returns to unassigned.
// RULE13: The minute counter starts with a user test and resets whenever the test ends.
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ttya_ctl #(
  parameter longint CYC_PER_MIN = ttya_pkg::MIN_CYC
) (
  input  wire logic                                    sys_clk,
  input  wire logic                                    resetn,
  input  wire ttya_pkg::ttya_avs_req_t                 avs_req,
  output var  ttya_pkg::ttya_avs_rsp_t                 avs_rsp,
  input  wire ttya_pkg::ttya_line_t [ttya_pkg::NUM_IF-1:0] line_status,
  input  wire logic                                    dte_loop_req,
  output var  logic [ttya_pkg::NUM_IF-1:0]             yellow_tx,
  output var  logic                                    loop_active,
  output var  logic                                    pattern_active,
  output var  logic                                    dte_loop_active,
  output var  logic                                    irq
);
  import ttya_pkg::*;

  if (SUSTAIN_CYC_L < 1 || SUSTAIN_CYC_L >= (64'h1 << SUS_W)) begin : g_bad_sus
    $error("Sustain count does not fit its counter");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    ttya_avs_rsp_t                   rsp;
    logic                            irq;
    logic                            yel_en;
    logic                            tmo_en;
    logic [DUR_W-1:0]                dur;
    ttya_test_t                      test;
    logic                            loop;
    logic                            pat;
    logic                            dte;
    logic [NSTAT-1:0]                stat;
    logic [NSTAT-1:0]                mask;
    logic [IDX_W-1:0]                aidx;
    logic [NUM_IF-1:0][SUS_W-1:0]    sus;
    logic [NUM_IF-1:0]               yel;
  } ttya_ctl_st_t;

  ttya_ctl_st_t q, d;

  logic              req;
  logic              acc;
  logic              wr_acc;
  logic              rd_acc;
  logic [31:0]       wd;
  logic [3:0]        be;
  logic [31:0]       rmux;
  logic [NUM_IF-1:0] fail;
  logic [NSTAT-1:0]  ev;
  logic [NSTAT-1:0]  rclr;
  logic [DUR_W-1:0]  wdur;
  logic [DUR_W-1:0]  minutes;
  logic              clr_busy;
  logic              clr_done;
  logic              clr_valid;
  logic              tbl_we;
  ttya_clr_req_t     clr_req;
  ttya_entry_t       tbl_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks

  ttya_minute_timer #(
    .CYC_PER_MIN (CYC_PER_MIN)
  ) u_timer (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .run     (q.test != TST_IDLE),
    .minutes (minutes)
  );

  ttya_clear_engine u_clear (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .sw_we     (tbl_we),
    .sw_idx    (q.aidx),
    .sw_wdata  (ttya_entry_t'(wd[7:0])),
    .sw_rdata  (tbl_rdata),
    .clr_valid (clr_valid),
    .clr_req   (clr_req),
    .busy      (clr_busy),
    .done      (clr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Request is held until waitrequest low; the accept edge is the one after
  assign req    = avs_req.read | avs_req.write;
  assign acc    = req & ~q.rsp.waitrequest;
  assign wr_acc = acc & avs_req.write;
  assign rd_acc = acc & avs_req.read;
  assign wd     = avs_req.writedata;
  assign be     = avs_req.byteenable;
  assign wdur   = wd[CTRL_DUR_LSB +: DUR_W];

  assign clr_req = '{cmd: ttya_clr_cmd_t'(wd[1:0]), iface: wd[CLR_IF_LSB +: IF_W], slot: wd[CLR_SLOT_LSB +: SLOT_W]};

  // Clear commands arriving while a walk runs are dropped
  assign clr_valid = wr_acc && avs_req.address == ADR_CLEAR && be[0] && be[1] && !clr_busy;
  assign tbl_we    = wr_acc && avs_req.address == ADR_ADATA && be[0] && !clr_busy;

  always_comb begin
    rmux = '0;
    unique case (avs_req.address)
      ADR_CTRL: begin
        rmux[CTRL_YEL_BIT]             = q.yel_en;
        rmux[CTRL_TMO_BIT]             = q.tmo_en;
        rmux[CTRL_DUR_LSB +: DUR_W]    = q.dur;
      end
      ADR_TEST: begin
        rmux[TEST_START_BIT]           = (q.test != TST_IDLE);
        rmux[TEST_KIND_BIT]            = q.pat;
        rmux[TEST_DTE_BIT]             = q.dte;
        rmux[TEST_MIN_LSB +: DUR_W]    = minutes;
      end
      ADR_CLEAR: rmux[CLR_BUSY_BIT]    = clr_busy;
      ADR_STAT:  rmux[NSTAT-1:0]       = q.stat;
      ADR_MASK:  rmux[NSTAT-1:0]       = q.mask;
      ADR_ALARM: begin
        rmux[NUM_IF-1:0]                  = q.yel;
        rmux[ALARM_FAIL_LSB +: NUM_IF]    = fail;
      end
      ADR_AIDX:  rmux[IDX_W-1:0]       = q.aidx;
      ADR_ADATA: rmux[7:0]             = tbl_rdata;
      default:   rmux = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line failure detect

  for (genvar i = 0; i < NUM_IF; i++) begin : g_fail
    assign fail[i] = line_status[i].signal_loss | line_status[i].frame_sync_loss |
                     line_status[i].all_ones_indication; // RULE1
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d    = q;
    ev   = '0;
    rclr = '0;

    // Slave handshake: one wait cycle, then a single ready cycle
    d.rsp.waitrequest = 1'b1;
    if (req && q.rsp.waitrequest) begin
      d.rsp.waitrequest = 1'b0;
      d.rsp.readdata    = avs_req.read ? rmux : '0;
    end

    // Register writes
    if (wr_acc) begin
      unique case (avs_req.address)
        ADR_CTRL: begin
          if (be[0]) begin
            d.yel_en = wd[CTRL_YEL_BIT];
            d.tmo_en = wd[CTRL_TMO_BIT];
          end
          if (be[1] && wdur >= DUR_MIN && wdur <= DUR_MAX) begin
            d.dur = wdur; // RULE7
          end
        end
        ADR_MASK: begin
          if (be[0]) begin
            d.mask = wd[NSTAT-1:0];
          end
        end
        ADR_AIDX: begin
          if (be[0]) begin
            d.aidx = wd[IDX_W-1:0];
          end
        end
        default: d.aidx = q.aidx;
      endcase
    end

    // User test control
    if (wr_acc && avs_req.address == ADR_TEST && be[0]) begin
      if (wd[TEST_STOP_BIT]) begin
        d.test = TST_IDLE; // RULE6
      end else if (wd[TEST_START_BIT] && q.test == TST_IDLE) begin
        d.test = wd[TEST_KIND_BIT] ? TST_PATTERN : TST_LOOP; // RULE13
      end
    end
    if (q.tmo_en && q.test != TST_IDLE && minutes >= q.dur && d.test != TST_IDLE) begin
      d.test          = TST_IDLE; // RULE4
      ev[ST_TIMEOUT]  = 1'b1;
    end
    d.loop = (d.test == TST_LOOP);
    d.pat  = (d.test == TST_PATTERN);

    // Terminal-requested loopback follows its request only
    d.dte       = dte_loop_req; // RULE5
    ev[ST_DTE]  = dte_loop_req & ~q.dte;

    // Yellow alarm after sustained failure
    for (int i = 0; i < NUM_IF; i++) begin
      if (!fail[i]) begin
        d.sus[i] = '0;
      end else if (q.sus[i] != SUSTAIN_CYC) begin
        d.sus[i] = q.sus[i] + 12'h001;
      end
      d.yel[i] = q.yel_en && fail[i] && (d.sus[i] == SUSTAIN_CYC); // RULE1 RULE2
    end
    ev[ST_YEL]     = |(d.yel & ~q.yel);
    ev[ST_CLRDONE] = clr_done;

    // Sticky status: read clears only the bits it returned
    if (rd_acc && avs_req.address == ADR_STAT) begin
      rclr = q.rsp.readdata[NSTAT-1:0];
    end
    d.stat = (q.stat & ~rclr) | ev;
    d.irq  = |(d.stat & d.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q                 <= '0;
      q.rsp.waitrequest <= 1'b1;
      q.yel_en          <= YEL_EN_RST;
      q.tmo_en          <= TMO_EN_RST;
      q.dur             <= DUR_RST; // RULE7
      q.test            <= TST_IDLE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_rsp         = q.rsp;
  assign yellow_tx       = q.yel;
  assign loop_active     = q.loop;
  assign pattern_active  = q.pat;
  assign dte_loop_active = q.dte;
  assign irq             = q.irq;
endmodule : ttya_ctl
`default_nettype wire

// ===== core/ttya_pkg.sv
// Shared constants, register map and carrier types of the test timeout and yellow alarm control
package ttya_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int NUM_IF    = 4;   // 0 net line 1, 1 net line 2, 2..3 drop/insert
  localparam int TS_PER_IF = 24;
  localparam int TBL_N     = NUM_IF * TS_PER_IF;
  localparam int IDX_W     = 7;
  localparam int IF_W      = 2;
  localparam int TS_W      = 5;
  localparam int SLOT_W    = 4;
  localparam int DUR_W     = 7;
  localparam int NSTAT     = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_TEST  = 8'h04;
  localparam logic [7:0] ADR_CLEAR = 8'h08;
  localparam logic [7:0] ADR_STAT  = 8'h0C;
  localparam logic [7:0] ADR_MASK  = 8'h10;
  localparam logic [7:0] ADR_ALARM = 8'h14;
  localparam logic [7:0] ADR_AIDX  = 8'h18;
  localparam logic [7:0] ADR_ADATA = 8'h1C;

  // Field positions
  localparam int CTRL_YEL_BIT  = 0;
  localparam int CTRL_TMO_BIT  = 1;
  localparam int CTRL_DUR_LSB  = 8;
  localparam int TEST_START_BIT = 0;
  localparam int TEST_STOP_BIT  = 1;
  localparam int TEST_KIND_BIT  = 2;
  localparam int TEST_DTE_BIT   = 3;
  localparam int TEST_MIN_LSB   = 8;
  localparam int CLR_IF_LSB     = 2;
  localparam int CLR_SLOT_LSB   = 8;
  localparam int CLR_BUSY_BIT   = 0;
  localparam int ALARM_FAIL_LSB = 4;
  localparam int ST_TIMEOUT = 0;
  localparam int ST_YEL     = 1;
  localparam int ST_CLRDONE = 2;
  localparam int ST_DTE     = 3;

  // Values after reset and limits
  localparam logic             YEL_EN_RST = 1'b1;
  localparam logic             TMO_EN_RST = 1'b1;
  localparam logic [DUR_W-1:0] DUR_RST    = 7'h0A;
  localparam logic [DUR_W-1:0] DUR_MIN    = 7'h01;
  localparam logic [DUR_W-1:0] DUR_MAX    = 7'h78;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam longint CLK_HZ     = 25_000_000;
  localparam longint MIN_SEC    = 60;
  localparam longint MIN_CYC    = MIN_SEC * CLK_HZ;
  localparam longint SUSTAIN_US = 100;
  localparam longint SUSTAIN_CYC_L = (SUSTAIN_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int     SUS_W      = 12;
  localparam logic [SUS_W-1:0] SUSTAIN_CYC = SUS_W'(SUSTAIN_CYC_L);

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {CLR_ALL, CLR_IFACE, CLR_SLOT, CLR_SLOT_SYNC} ttya_clr_cmd_t;
  typedef enum logic [1:0] {KIND_NONE, KIND_VOICE, KIND_SYNC, KIND_APM} ttya_kind_t;
  typedef enum logic [1:0] {TST_IDLE, TST_LOOP, TST_PATTERN} ttya_test_t;

  typedef struct packed {
    ttya_kind_t          kind;
    logic [1:0]          rsv;
    logic [SLOT_W-1:0]   slot;
  } ttya_entry_t;

  typedef struct packed {
    ttya_clr_cmd_t       cmd;
    logic [IF_W-1:0]     iface;
    logic [SLOT_W-1:0]   slot;
  } ttya_clr_req_t;

  typedef struct packed {
    logic                signal_loss;
    logic                frame_sync_loss;
    logic                all_ones_indication;
  } ttya_line_t;

  typedef struct packed {
    logic                read;
    logic                write;
    logic [7:0]          address;
    logic [31:0]         writedata;
    logic [3:0]          byteenable;
  } ttya_avs_req_t;

  typedef struct packed {
    logic [31:0]         readdata;
    logic                waitrequest;
  } ttya_avs_rsp_t;

endpackage : ttya_pkg

// ===== core/ttya_minute_timer.sv
// Minute counter for user test duration
`timescale 1ns/1ps
`default_nettype none
module ttya_minute_timer #(
  parameter longint CYC_PER_MIN = ttya_pkg::MIN_CYC
) (
  input  wire logic                          sys_clk,
  input  wire logic                          resetn,
  input  wire logic                          run,
  output var  logic [ttya_pkg::DUR_W-1:0]    minutes
);
  import ttya_pkg::*;

  if (CYC_PER_MIN < 1 || CYC_PER_MIN > 64'h0FFFFFFFF) begin : g_bad_cyc
    $error("CYC_PER_MIN out of range");
  end

  typedef struct packed {
    logic [31:0]      cyc;
    logic [DUR_W-1:0] mins;
  } ttya_mt_st_t;

  localparam logic [31:0] LAST = 32'(CYC_PER_MIN - 1);

  ttya_mt_st_t q, d;

  always_comb begin
    d = q;
    if (!run) begin
      d = '0; // RULE13
    end else if (q.cyc == LAST) begin
      d.cyc = '0;
      if (q.mins != '1) begin
        d.mins = q.mins + 7'h01; // RULE13
      end
    end else begin
      d.cyc = q.cyc + 32'h00000001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign minutes = q.mins;
endmodule : ttya_minute_timer
`default_nettype wire

// ===== core/ttya_clear_engine.sv
// Timeslot assignment table with clear walker
`timescale 1ns/1ps
`default_nettype none
module ttya_clear_engine (
  input  wire logic                            sys_clk,
  input  wire logic                            resetn,
  input  wire logic                            sw_we,
  input  wire logic [ttya_pkg::IDX_W-1:0]      sw_idx,
  input  wire ttya_pkg::ttya_entry_t           sw_wdata,
  output var  ttya_pkg::ttya_entry_t           sw_rdata,
  input  wire logic                            clr_valid,
  input  wire ttya_pkg::ttya_clr_req_t         clr_req,
  output var  logic                            busy,
  output var  logic                            done
);
  import ttya_pkg::*;

  typedef struct packed {
    ttya_entry_t [TBL_N-1:0] tbl;
    logic                    busy;
    logic                    done;
    ttya_clr_req_t           req;
    logic [IDX_W-1:0]        idx;
    logic [IF_W-1:0]         ifc;
    logic [TS_W-1:0]         ts;
  } ttya_ce_st_t;

  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(TBL_N - 1);
  localparam logic [TS_W-1:0]  TS_LAST  = TS_W'(TS_PER_IF - 1);

  ttya_ce_st_t q, d;
  ttya_entry_t cur;
  logic        hit;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    cur    = q.tbl[q.idx];
    unique case (q.req.cmd)
      CLR_ALL:       hit = 1'b1; // RULE9
      CLR_IFACE:     hit = (q.ifc == q.req.iface); // RULE10
      CLR_SLOT:      hit = (cur.kind != KIND_NONE) && (cur.slot == q.req.slot); // RULE11
      CLR_SLOT_SYNC: hit = (cur.kind == KIND_SYNC) && (cur.slot == q.req.slot); // RULE11
    endcase
    if (q.busy) begin
      if (hit) begin
        d.tbl[q.idx] = '0; // RULE12
      end
      if (q.idx == IDX_LAST) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.idx = q.idx + 7'h01;
        if (q.ts == TS_LAST) begin
          d.ts  = '0;
          d.ifc = q.ifc + 2'h1;
        end else begin
          d.ts = q.ts + 5'h01;
        end
      end
    end else if (clr_valid) begin
      d.busy = 1'b1;
      d.req  = clr_req;
      d.idx  = '0;
      d.ifc  = '0;
      d.ts   = '0;
    end else if (sw_we && sw_idx <= IDX_LAST) begin
      d.tbl[sw_idx] = sw_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sw_rdata = (sw_idx <= IDX_LAST) ? q.tbl[sw_idx] : '0;
  assign busy     = q.busy;
  assign done     = q.done;
endmodule : ttya_clear_engine
`default_nettype wire

// ===== dv/ttya_ctl_checker.sv
// Port-level assertions for the bus handshake, test timeout, terminal loopback and yellow alarm
`timescale 1ns/1ps
`default_nettype none
module ttya_ctl_checker #(
  parameter longint CYC_PER_MIN = ttya_pkg::MIN_CYC
) (
  input wire logic                                        sys_clk,
  input wire logic                                        resetn,
  input wire ttya_pkg::ttya_avs_req_t                     avs_req,
  input wire ttya_pkg::ttya_avs_rsp_t                     avs_rsp,
  input wire ttya_pkg::ttya_line_t [ttya_pkg::NUM_IF-1:0] line_status,
  input wire logic                                        dte_loop_req,
  input wire logic [ttya_pkg::NUM_IF-1:0]                 yellow_tx,
  input wire logic                                        loop_active,
  input wire logic                                        pattern_active,
  input wire logic                                        dte_loop_active,
  input wire logic                                        irq
);
  import ttya_pkg::*;
  logic             yel_q;
  logic             tmo_q;
  logic [DUR_W-1:0] dur_q;
  logic [2:0]       stop_q;
  longint           run_q;
  int               fcnt_q [NUM_IF];
  logic             acc_w;
  logic             act;
  logic [DUR_W-1:0] dur_w;
  assign acc_w = avs_req.write && !avs_rsp.waitrequest;
  assign act   = loop_active || pattern_active;
  assign dur_w = avs_req.writedata[CTRL_DUR_LSB +: DUR_W];
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of settings and run lengths
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      yel_q  <= YEL_EN_RST;
      tmo_q  <= TMO_EN_RST;
      dur_q  <= DUR_RST;
      stop_q <= 3'h0;
      run_q  <= 0;
      for (int i = 0; i < NUM_IF; i++) fcnt_q[i] <= 0;
    end else begin
      if (acc_w && avs_req.address == ADR_CTRL) begin
        yel_q <= avs_req.writedata[CTRL_YEL_BIT];
        tmo_q <= avs_req.writedata[CTRL_TMO_BIT];
        if (dur_w >= DUR_MIN && dur_w <= DUR_MAX) dur_q <= dur_w;
      end
      if (acc_w && avs_req.address == ADR_TEST && avs_req.writedata[TEST_STOP_BIT]) stop_q <= 3'h4;
      else if (stop_q != 3'h0) stop_q <= stop_q - 3'h1;
      run_q <= act ? run_q + 1 : 0;
      for (int i = 0; i < NUM_IF; i++) fcnt_q[i] <= (|line_status[i]) ? fcnt_q[i] + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_ack;
    !avs_rsp.waitrequest ##1 avs_rsp.waitrequest;
  endsequence
  AST_ACK_ONE: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest |=> s_ack)
    else $error("bus answer not one cycle long");
  AST_ACK_CAUSE: assert property (!avs_rsp.waitrequest |-> $past(avs_req.read) || $past(avs_req.write))
    else $error("bus answer without request");
  AST_DTE_HOLD: assert property ($past(resetn) && $past(dte_loop_req) |-> dte_loop_active)
    else $error("terminal loopback dropped");
  AST_TMO_END: assert property (tmo_q && act |-> run_q <= dur_q * CYC_PER_MIN + 4)
    else $error("user test outlived its duration");
  AST_TMO_MIN: assert property (tmo_q && $fell(act) && stop_q == 3'h0 |-> run_q >= dur_q * CYC_PER_MIN)
    else $error("user test ended early");
  AST_NO_TMO: assert property (!tmo_q && $fell(act) |-> stop_q != 3'h0)
    else $error("user test ended without stop");
  AST_NO_YEL: assert property (!yel_q && !$past(yel_q) |-> yellow_tx == '0)
    else $error("yellow sent while disabled");
  for (genvar i = 0; i < NUM_IF; i++) begin : g_line
    AST_YEL_CAUSE: assert property (yellow_tx[i] |-> $past(fcnt_q[i]) >= 2499)
      else $error("yellow without sustained failure");
    AST_YEL_LATE: assert property (yel_q && $past(yel_q) && fcnt_q[i] >= 2504 |-> yellow_tx[i])
      else $error("yellow missing on failing line");
  end
endmodule : ttya_ctl_checker
`default_nettype wire

// ===== dv/ttya_far_end.sv
// Behavioural model of the attached lines and terminal equipment
`timescale 1ns/1ps
`default_nettype none
module ttya_far_end (
  input  wire logic                                        sys_clk,
  input  wire ttya_pkg::ttya_line_t [ttya_pkg::NUM_IF-1:0] fail_cmd,
  input  wire logic                                        dte_cmd,
  input  wire logic                                        yel_off,
  output var  ttya_pkg::ttya_line_t [ttya_pkg::NUM_IF-1:0] line_status = '0,
  output var  logic                                        dte_loop_req = 1'b0,
  output var  logic                                        term_yellow = 1'b0
);
  import ttya_pkg::*;
  always @(posedge sys_clk) begin
    line_status  <= fail_cmd;
    dte_loop_req <= dte_cmd;
    term_yellow  <= yel_off && (|{line_status[0], line_status[1]});
  end
endmodule : ttya_far_end
`default_nettype wire

// ===== dv/ttya_ctl_test.sv
// Self-checking bench for the control block
`timescale 1ns/1ps
`default_nettype none
module ttya_ctl_test;
  import ttya_pkg::*;
  localparam longint CYC_PER_MIN = 20;
  logic                    sys_clk = 1'b0;
  logic                    resetn = 1'b0;
  ttya_avs_req_t           avs_req = '0;
  ttya_avs_rsp_t           avs_rsp;
  ttya_line_t [NUM_IF-1:0] line_status;
  ttya_line_t [NUM_IF-1:0] fail_cmd = '0;
  logic                    dte_cmd = 1'b0;
  logic                    yel_off = 1'b0;
  logic                    dte_loop_req, term_yellow, loop_active, pattern_active;
  logic                    dte_loop_active, irq;
  logic [NUM_IF-1:0]       yellow_tx;
  logic [31:0]             rdata;
  int                      err_total = 0;
  int                      comparisons = 0;
  int                      cycles = 0;
  int                      n;
  logic [6:0]              dur_try [5] = '{7'h00, 7'h79, 7'h78, 7'h01, 7'h7F};
  logic [6:0]              dur_exp [5] = '{7'h0A, 7'h0A, 7'h78, 7'h01, 7'h01};
  logic [6:0]              idx [4] = '{7'h00, 7'h18, 7'h30, 7'h5F};
  logic [7:0]              ent [4] = '{8'h43, 8'h83, 8'hC5, 8'h45};
  logic [31:0]             clr [4] = '{32'h0000_0303, 32'h0000_0009, 32'h0000_0502, 32'h0};
  logic [7:0]              clr_exp [4][4] = '{'{8'h43, 8'h00, 8'hC5, 8'h45},
    '{8'h43, 8'h00, 8'h00, 8'h45}, '{8'h43, 8'h00, 8'h00, 8'h00}, '{4{8'h00}}};
  always #20 sys_clk = ~sys_clk;
  ttya_ctl #(.CYC_PER_MIN(CYC_PER_MIN)) DUT (.sys_clk(sys_clk), .resetn(resetn),
    .avs_req(avs_req), .avs_rsp(avs_rsp), .line_status(line_status),
    .dte_loop_req(dte_loop_req), .yellow_tx(yellow_tx), .loop_active(loop_active),
    .pattern_active(pattern_active), .dte_loop_active(dte_loop_active), .irq(irq));
  ttya_far_end u_far (.sys_clk(sys_clk), .fail_cmd(fail_cmd), .dte_cmd(dte_cmd),
    .yel_off(yel_off), .line_status(line_status), .dte_loop_req(dte_loop_req),
    .term_yellow(term_yellow));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  // Called just after a rising edge; returns one edge after the answer
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    k = 0;
    avs_req.write      <= wr;
    avs_req.read       <= ~wr;
    avs_req.address    <= adr;
    avs_req.writedata  <= wd;
    avs_req.byteenable <= 4'hF;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_rsp.waitrequest !== 1'b0 && k < 20);
    rd = avs_rsp.readdata;
    if (k >= 20) check("waitrequest", 32'h0, 32'h1);
    avs_req.read  <= 1'b0;
    avs_req.write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    bus(1'b1, adr, wd, rdata);
  endtask : wr
  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input string what);
    bus(1'b0, adr, 32'h0, rdata);
    check(what, exp, rdata);
  endtask : rdc
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask : tick
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(2);
    resetn <= 1'b1;
    tick(1);
    rdc(ADR_CTRL, 32'h0000_0A03, "ctrl");
    rdc(ADR_STAT, 32'h0, "stat");
    rdc(8'h20, 32'h0, "unmapped");
    foreach (dur_try[i]) begin
      wr(ADR_CTRL, {17'h0, dur_try[i], 8'h03});
      rdc(ADR_CTRL, {17'h0, dur_exp[i], 8'h03}, "duration");
    end
    $display("end reset and duration");
    wr(ADR_MASK, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wr(ADR_CTRL, 32'h0000_0203);
      wr(ADR_TEST, {29'h0, k[0], 2'b01});
      tick(2);
      check("running", 32'h1, {31'h0, k[0] ? pattern_active : loop_active});
      n = 0;
      while ((loop_active | pattern_active) === 1'b1 && n < 100) begin
        tick(1);
        n++;
      end
      check("length", 32'h1, {31'h0, n + 4 >= 2 * CYC_PER_MIN && n <= 2 * CYC_PER_MIN + 2});
      tick(2);
      check("irq", 32'h1, {31'h0, irq});
      rdc(ADR_STAT, 32'h1, "stat timeout");
      rdc(ADR_TEST, 32'h0, "minutes");
      check("irq clear", 32'h0, {31'h0, irq});
    end
    $display("end timeout");
    wr(ADR_CTRL, 32'h0000_0101);
    wr(ADR_TEST, 32'h5);
    tick(5 * CYC_PER_MIN);
    check("held", 32'h1, {31'h0, pattern_active});
    wr(ADR_TEST, 32'h3);
    tick(2);
    check("stopped", 32'h0, {31'h0, pattern_active});
    rdc(ADR_TEST, 32'h0, "minutes");
    wr(ADR_CTRL, 32'h0000_0103);
    dte_cmd <= 1'b1;
    tick(4 * CYC_PER_MIN);
    check("dte loop", 32'h1, {31'h0, dte_loop_active});
    rdc(ADR_TEST, 32'h8, "test dte");
    dte_cmd <= 1'b0;
    tick(3);
    check("dte off", 32'h0, {31'h0, dte_loop_active});
    rdc(ADR_STAT, 32'h8, "stat dte");
    $display("end manual and dte");
    fail_cmd[0] <= 3'b100;
    fail_cmd[1] <= 3'b010;
    fail_cmd[2] <= 3'b001;
    tick(2400);
    check("yellow early", 32'h0, {28'h0, yellow_tx});
    fail_cmd[3] <= 3'b100;
    tick(200);
    check("yellow", 32'h7, {28'h0, yellow_tx});
    rdc(ADR_ALARM, 32'h0000_00F7, "alarm");
    wr(ADR_CTRL, 32'h0000_0102);
    yel_off <= 1'b1;
    tick(2600);
    check("yellow off", 32'h0, {28'h0, yellow_tx});
    check("term yellow", 32'h1, {31'h0, term_yellow});
    fail_cmd <= '0;
    wr(ADR_CTRL, 32'h0000_0103);
    yel_off <= 1'b0;
    rdc(ADR_STAT, 32'h2, "stat yellow");
    $display("end yellow");
    for (int i = 0; i < 4; i++) begin
      wr(ADR_AIDX, {25'h0, idx[i]});
      wr(ADR_ADATA, {24'h0, ent[i]});
    end
    wr(ADR_MASK, 32'h4);
    for (int c = 0; c < 4; c++) begin
      wr(ADR_CLEAR, clr[c]);
      n = 0;
      do begin
        bus(1'b0, ADR_CLEAR, 32'h0, rdata);
        n++;
      end while (rdata[0] !== 1'b0 && n < 100);
      for (int i = 0; i < 4; i++) begin
        wr(ADR_AIDX, {25'h0, idx[i]});
        rdc(ADR_ADATA, {24'h0, clr_exp[c][i]}, "entry");
      end
    end
    check("irq done", 32'h1, {31'h0, irq});
    rdc(ADR_STAT, 32'h4, "stat clear");
    $display("end clear");
    print_verdict();
  end
endmodule : ttya_ctl_test
bind ttya_ctl ttya_ctl_checker #(.CYC_PER_MIN(CYC_PER_MIN)) u_chk (.sys_clk(sys_clk),
  .resetn(resetn), .avs_req(avs_req), .avs_rsp(avs_rsp), .line_status(line_status),
  .dte_loop_req(dte_loop_req), .yellow_tx(yellow_tx), .loop_active(loop_active),
  .pattern_active(pattern_active), .dte_loop_active(dte_loop_active), .irq(irq));
`default_nettype wire
